// ### hw/pss_fsm.sv
// Principal switch selection state machine with disruptive reconfiguration handling.
// Assumes frame parsing and framing live outside; events arrive as one-cycle strobes.
`timescale 1ns/100ps
module pss_fsm import pss_pkg::*; #(
	parameter longint FSTOV_CYC = FSTOV_CYC_L // Stability timeout in clock cycles.
) (
	input wire logic ref_clk, // Switch clock, 200 MHz.
	input wire logic nrst, // Asynchronous reset, active low.
	input wire logic [VW-1:0] own_value, // Own priority and name.
	input wire logic [DW-1:0] own_domain, // Domain granted by distribution, 0 if none.
	input wire logic rcf_orig, // Management asks to originate an RCF.
	input wire logic domain_granted, // Pulse: new domain ID granted.
	input wire logic [NPORT-1:0] port_init_done, // Pulse per port: port init completed.
	input wire logic rx_valid, // Received frame strobe.
	input wire pss_code_type rx_code, // Received frame code.
	input wire logic [7:0] rx_type, // CT type.
	input wire logic [PW-1:0] rx_port, // Receiving port.
	input wire logic [VW-1:0] rx_value, // Received priority and name (EFP).
	input wire logic [NPORT*DW-1:0] rx_list, // Received domain records (EFP).
	input wire logic rx_is_req, // Received EFP is a request, not an accept.
	input wire pss_code_type tx_code, // Frame the switch wants to send.
	input wire logic [7:0] tx_type, // CT type of that frame.
	input wire logic [NPORT-1:0] tx_done, // Pulse per port: pending EFP, RCF or DIA sent.
	output logic [2:0] state_o, // Current state.
	output logic [1:0] rx_verdict_o, // Registered verdict on last frame.
	output logic rx_verdict_vld, // Pulse: verdict valid.
	output logic tx_allow_o, // Registered send permission.
	output logic [NPORT-1:0] rcf_send_o, // Ports owed an RCF.
	output logic [NPORT-1:0] efp_send_o, // Ports owed an EFP with the retained value.
	output logic [NPORT-1:0] dia_send_o, // Ports owed a DIA.
	output logic [NPORT-1:0] iso_o, // Isolated ports.
	output logic acc_vld, // Pulse: accept to send on acc_port.
	output logic [PW-1:0] acc_port, // Port of the accept.
	output logic [VW-1:0] acc_value, // Value carried by an EFP accept.
	output logic [VW-1:0] retained_o, // Retained lowest value / fabric name.
	output logic [PW-1:0] upstream_o, // Upstream principal port.
	output logic principal_o // Switch is principal.
);
	localparam logic [31:0] T1 = 32'(FSTOV_CYC);
	localparam logic [32:0] T2 = 33'(2 * FSTOV_CYC);

	typedef struct packed {
		pss_state_type st;
		logic post;
		logic [32:0] tmr;
		logic [NPORT-1:0] rcf_rx, rcf_tx, efp_tx, dia_tx, iso;
		logic [VW-1:0] ret;
		logic [NPORT*DW-1:0] list;
		logic [PW-1:0] up;
		logic prin;
		logic [1:0] vd;
		logic vdv, txa, accv;
		logic [PW-1:0] accp;
		logic [VW-1:0] accval;
	} pss_reg_type;

	pss_reg_type s_reg, s_next;
	logic rst_m, rst_s;
	logic [1:0] vd_c;
	logic txa_c;

	// True when no domain record is set.
	function automatic logic list_empty(input logic [NPORT*DW-1:0] l);
		return l == '0;
	endfunction

	// True when any record position holds the same nonzero domain in both lists.
	function automatic logic list_overlap(input logic [NPORT*DW-1:0] a,
		input logic [NPORT*DW-1:0] b);
		logic r;
		r = 1'b0;
		for (int i = 0; i < NPORT; i++) begin
			if (a[i*DW +: DW] != '0 && a[i*DW +: DW] == b[i*DW +: DW]) begin
				r = 1'b1;
			end
		end
		return r;
	endfunction

	// Release reset through two flops so removal is clean on the switch clock.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rst_m <= 1'b0;
			rst_s <= 1'b0;
		end else begin
			rst_m <= 1'b1;
			rst_s <= rst_m;
		end
	end

	pss_filter u_filter (
		.ref_clk(ref_clk),
		.rst_n(rst_s),
		.in_disr(s_reg.st == ST_DISR),
		.post_disr(s_reg.post),
		.rx_valid(rx_valid),
		.rx_code(rx_code),
		.rx_type(rx_type),
		.tx_code(tx_code),
		.tx_type(tx_type),
		.rx_verdict(vd_c),
		.tx_allow(txa_c)
	);

	// Next-state logic; the timer restarts on entry and on every change of the retained value.
	always_comb begin
		logic [NPORT-1:0] pm;
		logic [NPORT*DW-1:0] merged;
		logic chg;
		s_next = s_reg;
		pm = '0;
		merged = '0;
		chg = 1'b0;
		if (rx_valid) begin
			pm = NPORT'(1) << rx_port;
		end
		s_next.vdv = rx_valid;
		s_next.vd = vd_c;
		s_next.txa = txa_c;
		s_next.accv = 1'b0;
		s_next.tmr = (s_reg.tmr == T2) ? s_reg.tmr : s_reg.tmr + 33'h1;
		s_next.efp_tx = s_reg.efp_tx & ~tx_done;
		s_next.rcf_tx = s_reg.rcf_tx & ~tx_done;
		s_next.dia_tx = s_reg.dia_tx & ~tx_done;
		if (domain_granted) begin
			s_next.post = 1'b0;
		end
		if ((rcf_orig || (rx_valid && rx_code == FC_RCF)) && s_reg.st != ST_NDIS) begin
			// Enter disruptive reconfiguration; first RCF restarts the timer and the value.
			if (s_reg.st != ST_DISR) begin
				s_next.tmr = '0;
				s_next.list = '0;
				s_next.ret = own_value;
				s_next.rcf_rx = '0;
				s_next.prin = 1'b0;
			end
			s_next.st = ST_DISR;
			s_next.post = 1'b1;
			if (rx_valid && rx_code == FC_RCF) begin
				s_next.rcf_rx = s_next.rcf_rx | pm;
				s_next.accv = 1'b1;
				s_next.accp = rx_port;
			end
			// Owed RCFs are set once on entry; a later RCF only strikes its own port,
			// so neighbours already served are not asked a second time.
			if (s_reg.st != ST_DISR) begin
				s_next.rcf_tx = ~(s_next.rcf_rx | s_reg.iso);
			end else begin
				s_next.rcf_tx = s_next.rcf_tx & ~s_next.rcf_rx;
			end
		end else begin
			case (s_reg.st)
				ST_DISR: begin
					// An RCF seen before the port came up does not count, so it is owed one.
					s_next.rcf_rx = s_reg.rcf_rx & ~port_init_done;
					s_next.rcf_tx = s_next.rcf_tx | port_init_done;
					if (s_reg.tmr >= 33'(T1)) begin
						s_next.st = ST_IDLE;
						s_next.tmr = '0;
						s_next.efp_tx = ~s_reg.iso;
					end
				end
				ST_IDLE, ST_SEND: begin
					s_next.efp_tx = s_next.efp_tx | (port_init_done & ~s_reg.iso);
					if (rx_valid && rx_code == FC_DIA) begin
						s_next.st = ST_REQ;
						s_next.accv = 1'b1;
						s_next.accp = rx_port;
					end else if (rx_valid && rx_code == FC_EFP) begin
						s_next.st = ST_SEND;
						if (rx_is_req) begin
							s_next.accv = 1'b1;
							s_next.accp = rx_port;
							s_next.efp_tx = s_next.efp_tx & ~pm;
						end
						if (!list_empty(rx_list) && !list_empty(s_reg.list)) begin
							if (list_overlap(rx_list, s_reg.list)) begin
								s_next.iso = s_reg.iso | pm;
								s_next.st = ST_IDLE;
							end else if (rx_value != s_reg.ret) begin
								s_next.st = ST_NDIS;
							end else begin
								for (int i = 0; i < NPORT; i++) begin
									merged[i*DW +: DW] = (s_reg.list[i*DW +: DW] != '0) ?
										s_reg.list[i*DW +: DW] : rx_list[i*DW +: DW];
								end
								s_next.list = merged;
							end
						end else if (!list_empty(rx_list)) begin
							s_next.ret = rx_value;
							s_next.list = rx_list;
							s_next.up = rx_port;
							chg = (rx_value != s_reg.ret);
							s_next.st = ST_IDLE;
						end else if (!list_empty(s_reg.list)) begin
							if (own_domain != '0) begin
								s_next.dia_tx = s_next.dia_tx | pm;
							end
							s_next.st = ST_IDLE;
						end else begin
							if (rx_value < s_reg.ret) begin
								s_next.ret = rx_value;
								s_next.up = rx_port;
								chg = 1'b1;
							end
							s_next.st = ST_IDLE;
						end
						if (chg) begin
							// The newer value is owed to every port except the isolated ones and the sender.
							s_next.efp_tx = ~(s_reg.iso | pm);
							s_next.tmr = '0;
						end
						s_next.accval = s_next.ret;
					end else if (s_reg.st == ST_IDLE && s_reg.tmr == T2) begin
						if (s_reg.ret[VW-1 -: 8] == PRIO_NONE) begin
							s_next.iso = '1;
							s_next.st = ST_ISO;
						end else if (s_reg.ret == own_value) begin
							s_next.st = ST_PRIN;
							s_next.prin = 1'b1;
						end
					end
				end
				ST_CONF: begin
					if (port_init_done != '0) begin
						s_next.st = ST_IDLE;
						s_next.ret = own_value;
						s_next.tmr = '0;
						s_next.efp_tx = port_init_done;
					end
				end
				ST_PRIN, ST_REQ, ST_ISO, ST_NDIS: begin
					if (domain_granted) begin
						s_next.st = ST_CONF;
					end
				end
				default: begin
					s_next.st = ST_CONF;
				end
			endcase
		end
	end

	// Single state register; all outputs derive from it.
	always_ff @(posedge ref_clk or negedge rst_s) begin
		if (!rst_s) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	// Outputs come straight from the state register, so nothing downstream sees a glitch.
	assign state_o = s_reg.st;
	assign rx_verdict_o = s_reg.vd;
	assign rx_verdict_vld = s_reg.vdv;
	assign tx_allow_o = s_reg.txa;
	assign rcf_send_o = s_reg.rcf_tx;
	assign efp_send_o = s_reg.efp_tx;
	assign dia_send_o = s_reg.dia_tx;
	assign iso_o = s_reg.iso;
	assign acc_vld = s_reg.accv;
	assign acc_port = s_reg.accp;
	assign acc_value = s_reg.accval;
	assign retained_o = s_reg.ret;
	assign upstream_o = s_reg.up;
	assign principal_o = s_reg.prin;

	// Reconfiguration checks; outside ST_NDIS an RCF from management overrides any non-RCF frame in the same cycle.
	a_rcf_no_echo: assert property (@(posedge ref_clk) disable iff (!rst_s)
		(s_reg.st == ST_DISR) |-> (s_reg.rcf_tx & s_reg.rcf_rx) == '0) else
		$error("RCF owed to a port that sent one");
	a_rcf_enter: assert property (@(posedge ref_clk) disable iff (!rst_s)
		(rx_valid && rx_code == FC_RCF && s_reg.st != ST_NDIS) |=>
		s_reg.st == ST_DISR && s_reg.accv) else
		$error("RCF did not enter disruptive state");
	// A port that finishes init while disruptive is owed an RCF at once.
	a_rcf_init: assert property (@(posedge ref_clk) disable iff (!rst_s)
		(s_reg.st == ST_DISR && !rcf_orig && !(rx_valid && rx_code == FC_RCF) &&
		port_init_done != '0) |=>
		(s_reg.rcf_tx & $past(port_init_done)) == $past(port_init_done)) else
		$error("newly initialized port not owed an RCF");
	a_disr_wait: assert property (@(posedge ref_clk) disable iff (!rst_s)
		(s_reg.st == ST_DISR && s_next.st == ST_IDLE) |-> s_reg.tmr >= 33'(T1)) else
		$error("left disruptive before timeout");
	a_disr_clear: assert property (@(posedge ref_clk) disable iff (!rst_s)
		($rose(s_reg.st == ST_DISR)) |-> s_reg.list == '0 && s_reg.ret == $past(own_value)) else
		$error("reconfiguration start did not reset value and list");
	a_busy_reject: assert property (@(posedge ref_clk) disable iff (!rst_s)
		(rx_valid && s_reg.st == ST_DISR && rx_code == FC_OTHER) |=> s_reg.vdv &&
		s_reg.vd == VD_BUSY) else $error("busy reject missing");
	a_prin_entry: assert property (@(posedge ref_clk) disable iff (!rst_s)
		(s_reg.st == ST_IDLE && s_next.st == ST_PRIN) |-> s_reg.tmr == T2 &&
		s_reg.ret == own_value) else $error("principal chosen too early");
	a_iso_all: assert property (@(posedge ref_clk) disable iff (!rst_s)
		(s_reg.st == ST_IDLE && s_reg.tmr == T2 && !rx_valid && !rcf_orig &&
		s_reg.ret[VW-1 -: 8] == PRIO_NONE) |=> s_reg.iso == '1 && s_reg.st == ST_ISO) else
		$error("ports not isolated");
	a_dia_req: assert property (@(posedge ref_clk) disable iff (!rst_s)
		(rx_valid && rx_code == FC_DIA && !rcf_orig &&
		(s_reg.st == ST_IDLE || s_reg.st == ST_SEND)) |=> s_reg.st == ST_REQ) else
		$error("DIA ignored");
	a_acc_value: assert property (@(posedge ref_clk) disable iff (!rst_s)
		(s_reg.accv && $past(rx_code) == FC_EFP) |-> s_reg.accval == s_reg.ret) else
		$error("EFP accept value not lowest");
	// Merging rules; both exchange states share them, and only an equal-value merge stays in send.
	a_efp_adopt: assert property (@(posedge ref_clk) disable iff (!rst_s)
		(rx_valid && rx_code == FC_EFP && !rcf_orig && (s_reg.st == ST_IDLE ||
		s_reg.st == ST_SEND) && rx_list != '0 && s_reg.list == '0) |=>
		s_reg.up == $past(rx_port) && s_reg.ret == $past(rx_value)) else
		$error("received list not adopted");
	a_efp_lower: assert property (@(posedge ref_clk) disable iff (!rst_s)
		(rx_valid && rx_code == FC_EFP && !rcf_orig && (s_reg.st == ST_IDLE ||
		s_reg.st == ST_SEND) && rx_list == '0 && s_reg.list == '0 &&
		rx_value < s_reg.ret) |=> s_reg.up == $past(rx_port) &&
		s_reg.ret == $past(rx_value)) else
		$error("lower value not retained");
	a_efp_keep: assert property (@(posedge ref_clk) disable iff (!rst_s)
		(rx_valid && rx_code == FC_EFP && !rcf_orig && (s_reg.st == ST_IDLE ||
		s_reg.st == ST_SEND) && rx_list == '0 && s_reg.list != '0) |=>
		s_reg.ret == $past(s_reg.ret) && ($past(own_domain) == '0 ||
		s_reg.dia_tx[$past(rx_port)])) else $error("own value not kept or DIA not owed");
	a_overlap_iso: assert property (@(posedge ref_clk) disable iff (!rst_s)
		(rx_valid && rx_code == FC_EFP && !rcf_orig && (s_reg.st == ST_IDLE ||
		s_reg.st == ST_SEND) && rx_list != '0 && s_reg.list != '0 &&
		list_overlap(rx_list, s_reg.list)) |=> s_reg.iso[$past(rx_port)]) else
		$error("overlapping port not isolated");
	a_ndis_enter: assert property (@(posedge ref_clk) disable iff (!rst_s)
		(rx_valid && rx_code == FC_EFP && !rcf_orig && (s_reg.st == ST_IDLE ||
		s_reg.st == ST_SEND) && rx_list != '0 && s_reg.list != '0 &&
		!list_overlap(rx_list, s_reg.list) && rx_value != s_reg.ret) |=>
		s_reg.st == ST_NDIS) else $error("differing lists did not leave selection");
endmodule

// ### hw/pss_pkg.sv
// Package for the principal switch selection state machine.
// Assumes a single switch clock domain; shared by the FSM and its frame filter.
package pss_pkg;
	localparam int NPORT = 8;
	localparam int PW = 3;
	localparam int VW = 72; // Priority (8) concatenated with 64-bit switch name.
	localparam int DW = 8;
	localparam int FSTOV_MS = 5000;
	localparam int CLK_KHZ = 200000;
	localparam longint FSTOV_CYC_L = longint'(FSTOV_MS) * longint'(CLK_KHZ);
	localparam logic [7:0] PRIO_NONE = 8'hff;
	localparam logic [7:0] CT_DS_TYPE = 8'h20;
	// Frame codes presented on the receive and transmit request ports.
	typedef enum logic [3:0] {
		FC_ACC = 4'h0, FC_RJT = 4'h1, FC_ELP = 4'h2, FC_ESC = 4'h3,
		FC_RCF = 4'h4, FC_HLO = 4'h5, FC_LSU = 4'h6, FC_LSA = 4'h7,
		FC_EFP = 4'h8, FC_DIA = 4'h9, FC_RDI = 4'ha, FC_OTHER = 4'hb,
		FC_BF = 4'hc, FC_CT = 4'hd
	} pss_code_type;
	// Filter verdicts.
	localparam logic [1:0] VD_PASS = 2'h0;
	localparam logic [1:0] VD_DROP = 2'h1;
	localparam logic [1:0] VD_BUSY = 2'h2;
	localparam logic [1:0] VD_FRJT = 2'h3;
	typedef enum logic [2:0] {
		ST_CONF = 3'h0, ST_DISR = 3'h1, ST_IDLE = 3'h3, ST_SEND = 3'h2,
		ST_PRIN = 3'h6, ST_REQ = 3'h7, ST_ISO = 3'h5, ST_NDIS = 3'h4
	} pss_state_type;
endpackage

// ### hw/pss_filter.sv
// Frame filter for the reconfiguration window: classifies received and outgoing frames.
// Assumes the caller supplies the current state and the pending-grant flag on the same clock.
`timescale 1ns/100ps
module pss_filter import pss_pkg::*; (
	input wire logic ref_clk, // Switch clock.
	input wire logic rst_n, // Synchronised reset, active low.
	input wire logic in_disr, // Disruptive state.
	input wire logic post_disr, // Disruptive entered, no domain granted yet.
	input wire logic rx_valid, // Received frame strobe.
	input wire pss_code_type rx_code, // Received frame code.
	input wire logic [7:0] rx_type, // CT type of a received CT frame.
	input wire pss_code_type tx_code, // Code the switch wants to send.
	input wire logic [7:0] tx_type, // CT type of an outgoing CT frame.
	output logic [1:0] rx_verdict, // Combinational verdict on the received frame.
	output logic tx_allow // Combinational permission to send.
);
	// Verdict on a received frame; drops win over rejects so idle link traffic stays silent.
	always_comb begin
		rx_verdict = VD_PASS;
		if (in_disr || post_disr) begin
			if (rx_code == FC_HLO || rx_code == FC_LSU || rx_code == FC_LSA) begin
				rx_verdict = VD_DROP;
			end else if (rx_code == FC_CT) begin
				rx_verdict = (rx_type == CT_DS_TYPE) ? VD_FRJT : VD_PASS;
			end else if (rx_code == FC_ACC || rx_code == FC_RJT || rx_code == FC_ELP ||
				rx_code == FC_ESC || rx_code == FC_RCF) begin
				rx_verdict = VD_PASS;
			end else if (!in_disr && post_disr && (rx_code == FC_EFP || rx_code == FC_DIA ||
				rx_code == FC_RDI)) begin
				rx_verdict = VD_PASS;
			end else begin
				rx_verdict = VD_BUSY;
			end
		end
	end
	// Transmit gate; disruptive sends only replies and RCF, afterwards also the exchange set.
	always_comb begin
		tx_allow = 1'b1;
		if (in_disr) begin
			tx_allow = (tx_code == FC_ACC || tx_code == FC_RJT || tx_code == FC_RCF);
		end else if (post_disr) begin
			tx_allow = (tx_code == FC_ACC || tx_code == FC_RJT || tx_code == FC_RCF ||
				tx_code == FC_EFP || tx_code == FC_DIA || tx_code == FC_RDI);
		end
		if ((in_disr || post_disr) && tx_code == FC_CT && tx_type == CT_DS_TYPE) begin
			tx_allow = 1'b0;
		end
	end
	// A reject must never be the verdict while outside the window.
	a_filter_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(!in_disr && !post_disr) |-> rx_verdict == VD_PASS && tx_allow) else
		$error("filter acted outside reconfiguration");
	a_disr_no_efp: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(in_disr && tx_code == FC_EFP) |-> !tx_allow) else
		$error("EFP allowed in disruptive state");
	// The exchange set passes only with in_disr low, so it stays busy while disruptive whatever the pending-grant flag.
	a_exch_busy: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(rx_valid && in_disr && (rx_code == FC_EFP || rx_code == FC_DIA ||
		rx_code == FC_RDI)) |-> rx_verdict == VD_BUSY) else
		$error("exchange frame not busy while disruptive");
	a_ct_reject: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(rx_valid && (in_disr || post_disr) && rx_code == FC_CT && rx_type == CT_DS_TYPE)
		|-> rx_verdict == VD_FRJT) else $error("services frame not rejected");
endmodule

// ### tb/pss_peer.sv
// Neighbour switch model: sends the EFP or RCF frames that the FSM owes each port.
// Assumes the owed masks are registered on ref_clk and cleared by a one-cycle tx_done pulse.
`timescale 1ns/100ps
module pss_peer import pss_pkg::*; (
	input wire logic ref_clk, // Switch clock.
	input wire logic en, // The model answers only while this is high.
	input wire logic [7:0] lat, // Cycles before an owed frame goes out.
	input wire logic [NPORT-1:0] owed, // Ports owed an EFP or RCF.
	output logic [NPORT-1:0] tx_done // Pulse per port: owed frame sent.
);
	logic [7:0] cnt [NPORT];
	// Each owed port waits lat cycles, pulses once, then holds until the debt clears,
	// so a slow clear in the FSM draws no second pulse, unless lat is 255 and the count wraps to 0.
	always @(posedge ref_clk) begin
		for (int p = 0; p < NPORT; p++) begin
			tx_done[p] <= 1'b0;
			if (!en || !owed[p]) begin
				cnt[p] <= 8'h00;
			end else if (cnt[p] == lat) begin
				tx_done[p] <= 1'b1;
				cnt[p] <= cnt[p] + 8'h01;
			end else if (cnt[p] < lat) begin
				cnt[p] <= cnt[p] + 8'h01;
			end
		end
	end
endmodule

// ### tb/principal_switch_selection_fsm_bench.sv
// Self-checking bench for the principal switch selection FSM.
// Assumes a shortened stability timeout; the peer model clears owed frames.
`timescale 1ns/100ps
module principal_switch_selection_fsm_bench import pss_pkg::*;;
	localparam int FS = 60;
	localparam logic [VW-1:0] V_OWN = 72'h40_0000_0000_0000_00aa;
	localparam logic [VW-1:0] V_LOW = 72'h10_0000_0000_0000_0022;
	localparam logic [VW-1:0] V_HI = 72'h80_0000_0000_0000_0033;
	localparam logic [VW-1:0] V_OTH = 72'h20_0000_0000_0000_0044;
	localparam logic [VW-1:0] V_FF = 72'hff_0000_0000_0000_0055;
	typedef struct packed {
		logic ph;
		pss_code_type rc;
		logic [7:0] rt;
		logic [1:0] v;
		pss_code_type tc;
		logic [7:0] tt;
		logic al;
	} pss_row_type;
	logic ref_clk, nrst, rcf_orig, domain_granted, rx_valid, rx_is_req, pen;
	logic [VW-1:0] own_value, rx_value, acc_value, retained_o;
	logic [DW-1:0] own_domain;
	logic [NPORT-1:0] port_init_done, tx_done, rcf_send_o, efp_send_o, dia_send_o, iso_o;
	pss_code_type rx_code, tx_code;
	logic [7:0] rx_type, tx_type, plat;
	logic [PW-1:0] rx_port, acc_port, upstream_o;
	logic [NPORT*DW-1:0] rx_list;
	logic [2:0] state_o;
	logic [1:0] rx_verdict_o;
	logic rx_verdict_vld, tx_allow_o, acc_vld, principal_o;
	int n_fail = 0;
	int n_checks = 0;
	int cyc = 0;
	int t0, k;
	// Phase 0 rows run in the disruptive state, phase 1 rows after it, before a grant.
	pss_row_type rows [20] = '{
		'{1'b0, FC_ACC, 8'h00, VD_PASS, FC_ACC, 8'h00, 1'b1},
		'{1'b0, FC_RJT, 8'h00, VD_PASS, FC_RJT, 8'h00, 1'b1},
		'{1'b0, FC_ELP, 8'h00, VD_PASS, FC_RCF, 8'h00, 1'b1},
		'{1'b0, FC_ESC, 8'h00, VD_PASS, FC_EFP, 8'h00, 1'b0},
		'{1'b0, FC_HLO, 8'h00, VD_DROP, FC_HLO, 8'h00, 1'b0},
		'{1'b0, FC_LSU, 8'h00, VD_DROP, FC_DIA, 8'h00, 1'b0},
		'{1'b0, FC_LSA, 8'h00, VD_DROP, FC_RDI, 8'h00, 1'b0},
		'{1'b0, FC_EFP, 8'h00, VD_BUSY, FC_LSU, 8'h00, 1'b0},
		'{1'b0, FC_DIA, 8'h00, VD_BUSY, FC_CT, 8'h20, 1'b0},
		'{1'b0, FC_RDI, 8'h00, VD_BUSY, FC_LSA, 8'h00, 1'b0},
		'{1'b0, FC_OTHER, 8'h00, VD_BUSY, FC_OTHER, 8'h00, 1'b0},
		'{1'b0, FC_CT, 8'h20, VD_FRJT, FC_ACC, 8'h00, 1'b1},
		'{1'b1, FC_OTHER, 8'h00, VD_BUSY, FC_EFP, 8'h00, 1'b1},
		'{1'b1, FC_HLO, 8'h00, VD_DROP, FC_DIA, 8'h00, 1'b1},
		'{1'b1, FC_LSU, 8'h00, VD_DROP, FC_RDI, 8'h00, 1'b1},
		'{1'b1, FC_LSA, 8'h00, VD_DROP, FC_HLO, 8'h00, 1'b0},
		'{1'b1, FC_CT, 8'h20, VD_FRJT, FC_CT, 8'h20, 1'b0},
		'{1'b1, FC_ACC, 8'h00, VD_PASS, FC_LSA, 8'h00, 1'b0},
		'{1'b1, FC_ESC, 8'h00, VD_PASS, FC_OTHER, 8'h00, 1'b0},
		'{1'b1, FC_ELP, 8'h00, VD_PASS, FC_RCF, 8'h00, 1'b1}};

	pss_fsm #(.FSTOV_CYC(FS)) i_dut (.ref_clk, .nrst, .own_value, .own_domain, .rcf_orig,
		.domain_granted, .port_init_done, .rx_valid, .rx_code, .rx_type, .rx_port, .rx_value,
		.rx_list, .rx_is_req, .tx_code, .tx_type, .tx_done, .state_o, .rx_verdict_o,
		.rx_verdict_vld, .tx_allow_o, .rcf_send_o, .efp_send_o, .dia_send_o, .iso_o, .acc_vld,
		.acc_port, .acc_value, .retained_o, .upstream_o, .principal_o);
	pss_peer i_peer (.ref_clk, .en(pen), .lat(plat), .owed(efp_send_o | rcf_send_o), .tx_done);

	// Free-running clock and a cycle count used for timeout measurements.
	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) cyc <= cyc + 1;

	task chk(input logic [79:0] seen, input logic [79:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task print_verdict;
		if (n_fail == 0 && n_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// Inputs always change 1 ns after the edge, so the FSM never races the bench.
	task tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task frame(input pss_code_type c, input logic [7:0] t, input logic [PW-1:0] p,
		input logic [VW-1:0] v, input logic [NPORT*DW-1:0] l);
		rx_valid = 1'b1;
		rx_code = c;
		rx_type = t;
		rx_port = p;
		rx_value = v;
		rx_list = l;
		rx_is_req = 1'b1;
		tick(1);
		rx_valid = 1'b0;
	endtask
	// Bounded wait for a state; a miss ends the run rather than hanging it.
	task wait_st(input logic [2:0] s, input int lim);
		k = 0;
		while (state_o !== s && k < lim) begin
			tick(1);
			k++;
		end
		if (state_o !== s) begin
			chk(state_o, s);
			print_verdict();
		end
	endtask
	task do_reset(input logic [VW-1:0] v);
		nrst = 1'b0;
		own_value = v;
		own_domain = 8'h00;
		pen = 1'b0;
		tick(20);
		chk({principal_o, state_o, iso_o, efp_send_o, rcf_send_o}, 80'h0);
		nrst = 1'b1;
		tick(5);
	endtask
	task run_rcf(input logic [VW-1:0] v);
		do_reset(v);
		rcf_orig = 1'b1;
		tick(1);
		rcf_orig = 1'b0;
		chk({state_o, rcf_send_o}, {ST_DISR, 8'hff});
		pen = 1'b1;
		plat = 8'h01;
		wait_st(ST_IDLE, FS + 10);
	endtask
	task run_rows(input logic ph);
		for (int i = 0; i < 20; i++) begin
			if (rows[i].ph == ph) begin
				tx_code = rows[i].tc;
				tx_type = rows[i].tt;
				frame(rows[i].rc, rows[i].rt, 3'h0, V_OWN, '0);
				chk({rx_verdict_vld, rx_verdict_o}, {1'b1, rows[i].v});
				chk(tx_allow_o, rows[i].al);
				tick(1);
			end
		end
	endtask

	// Main sequence: reception table, then merging cases, then the timeout endings.
	initial begin
		{nrst, rcf_orig, domain_granted, rx_valid, rx_is_req, pen} = 6'h00;
		{port_init_done, rx_type, tx_type, rx_port, rx_value, rx_list} = '0;
		rx_code = FC_ACC;
		tx_code = FC_ACC;
		own_value = V_OWN;
		own_domain = 8'h00;
		plat = 8'h09;
		do_reset(V_OWN);
		t0 = cyc;
		frame(FC_RCF, 8'h00, 3'h2, V_OWN, '0);
		chk({state_o, acc_vld, acc_port, rx_verdict_o}, {ST_DISR, 1'b1, 3'h2, VD_PASS});
		chk(rcf_send_o, 8'hfb);
		tick(1);
		frame(FC_RCF, 8'h00, 3'h5, V_OWN, '0);
		chk({acc_vld, acc_port, rcf_send_o[5]}, {1'b1, 3'h5, 1'b0});
		tick(1);
		port_init_done = 8'h20;
		tick(1);
		port_init_done = 8'h00;
		chk(rcf_send_o[5], 1'b1);
		run_rows(1'b0);
		wait_st(ST_IDLE, FS + 10);
		chk(cyc - t0 >= FS && cyc - t0 <= FS + 3, 1'b1);
		chk(efp_send_o, 8'hff);
		run_rows(1'b1);
		pen = 1'b1;
		frame(FC_EFP, 8'h00, 3'h4, V_LOW, '0);
		chk({acc_vld, acc_port, acc_value}, {1'b1, 3'h4, V_LOW});
		tick(1);
		chk({retained_o, upstream_o, efp_send_o[0], efp_send_o[4]}, {V_LOW, 3'h4, 2'b10});
		frame(FC_EFP, 8'h00, 3'h6, V_HI, 64'h05);
		tick(1);
		chk({retained_o, upstream_o}, {V_HI, 3'h6});
		own_domain = 8'h07;
		frame(FC_EFP, 8'h00, 3'h3, V_LOW, '0);
		tick(1);
		chk({retained_o, dia_send_o[3]}, {V_HI, 1'b1});
		frame(FC_EFP, 8'h00, 3'h1, V_HI, 64'h05);
		tick(1);
		chk(iso_o[1], 1'b1);
		frame(FC_EFP, 8'h00, 3'h5, V_OTH, 64'h0900);
		wait_st(ST_NDIS, 4);
		domain_granted = 1'b1;
		tick(1);
		domain_granted = 1'b0;
		run_rcf(V_OWN);
		wait_st(ST_PRIN, 3 * FS);
		chk({principal_o, retained_o}, {1'b1, V_OWN});
		chk(k >= 2 * FS - 2, 1'b1);
		run_rcf(V_FF);
		wait_st(ST_ISO, 3 * FS);
		chk(iso_o, 8'hff);
		run_rcf(V_OWN);
		frame(FC_DIA, 8'h00, 3'h0, V_OWN, '0);
		chk(state_o, ST_REQ);
		print_verdict();
	end
endmodule
